// >>> design/ssd_split_start.sv
// Split screen start address and per-line fetch address selection
//
// Local design decision: the plain strobed port.
`include "ssd_consts.svh"
`timescale 1ns/100ps
`default_nettype none
// Function
// [R1] One start address step moves the image a whole word of pixels.
// [R2] Software scrolls by adding or subtracting one virtual line's word count.
// [R3] Start address is high byte times 256 plus low byte.
// [R4] First image sits at top, fetched from screen 1 start.
// [R5] After vertical size lines, fetch continues from screen 2 start.
// [R6] Vertical size is ten bits: low byte plus two high-register bits.
// [R7] Vertical size at or beyond displayed lines means no second image.
// [R8] Line counting starts at the end of vertical non-display.
// [R9] Screen 2 start may be any value, even below or equal screen 1.
// [R10] Screen 2 start is a 15-bit word offset, bit 7 reserved.
// [R11] Rotated mode disables the split and ignores screen 2 start.
// [R12] Split line is programmable to any display line.
// [R13] Word holds 16, 8, 4 or 2 pixels at 1, 2, 4, 8 bpp.
// [R14] Rotated mode treats screen 1 start as a byte offset.
// [R15] Settings are sampled once per frame at end of non-display; bpp and pix_per_step follow the control register at once.
// [R16] Next line address is previous plus width plus virtual offset.
module ssd_split_start
  import ssd_pkg::*;
(
  input  wire logic        sys_clk,       // System clock, 25 MHz
  input  wire logic        rst_n,         // Async reset, active low
  input  wire logic [5:0]  reg_addr,      // Register address
  input  wire logic [7:0]  reg_wdata,     // Register write data
  input  wire logic        reg_wr,        // Write strobe
  input  wire logic        reg_rd,        // Read strobe
  output logic      [7:0]  reg_rdata,     // Read data, cycle after strobe
  input  wire logic        vnd_end,       // End of vertical non-display pulse
  input  wire logic        line_end,      // End of displayed line pulse
  input  wire logic        line_valid,    // Displayed line is active
  output ssd_line_req_t    line_req,      // Current line fetch request
  output ssd_bpp_t         bpp,           // Programmed colour depth
  output logic      [4:0]  pix_per_step   // Pixels moved per start step
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] s1_lo, s1_hi, s2_lo, s2_hi, ofs_q, vs_lo, vs_hi, ctrl_q, width_q;
  logic [7:0] wr_sel;
  logic [5:0] addr_tab [8];

  assign addr_tab[0] = `SSD_OFS_S1_LO;
  assign addr_tab[1] = `SSD_OFS_S1_HI;
  assign addr_tab[2] = `SSD_OFS_S2_LO;
  assign addr_tab[3] = `SSD_OFS_S2_HI;
  assign addr_tab[4] = `SSD_OFS_OFFSET;
  assign addr_tab[5] = `SSD_OFS_VSIZE_LO;
  assign addr_tab[6] = `SSD_OFS_VSIZE_HI;
  assign addr_tab[7] = `SSD_OFS_CTRL;

  // Address decode for the byte registers
  for (genvar i = 0; i < 8; i++) begin : g_dec
    assign wr_sel[i] = reg_wr && (reg_addr == addr_tab[i]);
  end

  ssd_reg_byte #(.MASK(8'hFF)) u_s1_lo (
    .sys_clk (sys_clk), .rst_n (rst_n), .wr_en (wr_sel[0]),
    .wr_data (reg_wdata), .q (s1_lo));
  ssd_reg_byte #(.MASK(`SSD_HI_ADDR_MSK)) u_s1_hi (
    .sys_clk (sys_clk), .rst_n (rst_n), .wr_en (wr_sel[1]),
    .wr_data (reg_wdata), .q (s1_hi));
  ssd_reg_byte #(.MASK(8'hFF)) u_s2_lo (
    .sys_clk (sys_clk), .rst_n (rst_n), .wr_en (wr_sel[2]),
    .wr_data (reg_wdata), .q (s2_lo));
  // Bit 7 of the high byte is reserved and reads zero
  ssd_reg_byte #(.MASK(`SSD_HI_ADDR_MSK)) u_s2_hi ( // [R10]
    .sys_clk (sys_clk), .rst_n (rst_n), .wr_en (wr_sel[3]),
    .wr_data (reg_wdata), .q (s2_hi));
  ssd_reg_byte #(.MASK(8'hFF)) u_ofs (
    .sys_clk (sys_clk), .rst_n (rst_n), .wr_en (wr_sel[4]),
    .wr_data (reg_wdata), .q (ofs_q));
  ssd_reg_byte #(.MASK(8'hFF)) u_vs_lo (
    .sys_clk (sys_clk), .rst_n (rst_n), .wr_en (wr_sel[5]),
    .wr_data (reg_wdata), .q (vs_lo));
  // Only bits 1..0 of the size high byte exist
  ssd_reg_byte #(.MASK(`SSD_HI_VSIZE_MSK)) u_vs_hi ( // [R6]
    .sys_clk (sys_clk), .rst_n (rst_n), .wr_en (wr_sel[6]),
    .wr_data (reg_wdata), .q (vs_hi));
  // Control: bits 1..0 colour depth, bit 2 rotated display mode
  ssd_reg_byte #(.MASK(8'h07)) u_ctrl (
    .sys_clk (sys_clk), .rst_n (rst_n), .wr_en (wr_sel[7]),
    .wr_data (reg_wdata), .q (ctrl_q));

  // Displayed width in words; reset to all ones so a fresh setup shows a line
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      width_q <= 8'hFF;
    end else if (reg_wr && reg_addr == `SSD_OFS_WIDTH) begin
      width_q <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Assembled register values
  // ---------------------------------------------------------------
  logic [14:0] s1_word, s2_word;
  logic [9:0]  vsize_reg;

  assign s1_word   = 15'({s1_hi[6:0], `SSD_RST_BYTE} + {7'h00, s1_lo}); // [R3]
  assign s2_word   = {s2_hi[6:0], s2_lo};                               // [R10]
  assign vsize_reg = {vs_hi[1:0], vs_lo};                               // [R6]
  assign bpp       = ssd_bpp_t'(ctrl_q[1:0]);

  // ---------------------------------------------------------------
  // Per-frame snapshot of settings
  // ---------------------------------------------------------------
  ssd_frame_cfg_t cfg_ff;

  // Taken only at frame start so a frame never mixes old and new values
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= '0;
      cfg_ff.vsize <= `SSD_RST_VSIZE;
    end else if (vnd_end) begin
      cfg_ff.s1_start <= s1_word;    // [R15]
      cfg_ff.s2_start <= s2_word;    // [R9]
      cfg_ff.vsize    <= vsize_reg;  // [R15]
      cfg_ff.offset   <= ofs_q;
      cfg_ff.width    <= width_q;
      cfg_ff.rotated  <= ctrl_q[2];
    end
  end

  // ---------------------------------------------------------------
  // Word to byte conversion
  // ---------------------------------------------------------------
  logic [15:0] s1_byte, s2_byte, pitch;

  // Landscape starts are word offsets, rotated screen 1 start is a byte
  assign s1_byte = cfg_ff.rotated ? {1'b0, cfg_ff.s1_start}       // [R14]
                                  : {cfg_ff.s1_start, 1'b0};      // [R1]
  assign s2_byte = {cfg_ff.s2_start, 1'b0};                       // [R1]
  // Line pitch in bytes: displayed words doubled plus the extra bytes
  assign pitch   = 16'({7'h00, cfg_ff.width, 1'b0} + {8'h00, cfg_ff.offset}); // [R16]

  // Panning granularity reported to the pixel path
  always_comb begin
    unique case (bpp)
      SSD_BPP1: pix_per_step = 5'd16; // [R13]
      SSD_BPP2: pix_per_step = 5'd8;  // [R13]
      SSD_BPP4: pix_per_step = 5'd4;  // [R13]
      SSD_BPP8: pix_per_step = 5'd2;  // [R13]
    endcase
    if (ctrl_q[2]) begin
      pix_per_step = pix_per_step >> 1; // [R14]
    end
  end

  // ---------------------------------------------------------------
  // Line counter and image selection
  // ---------------------------------------------------------------
  logic [9:0] line_cnt_ff;
  logic       sat_ff;
  logic       second_ff;
  logic       hit_split;

  // Count displayed lines from the end of non-display; stops after wrapping to zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_cnt_ff <= 10'h000;
      sat_ff      <= 1'b0;
    end else if (vnd_end) begin
      line_cnt_ff <= 10'h000; // [R8]
      sat_ff      <= 1'b0;
    end else if (line_end && line_valid && !sat_ff) begin
      line_cnt_ff <= 10'(line_cnt_ff + 10'h001);
      sat_ff      <= (line_cnt_ff == 10'h3FF);
    end
  end

  // Split when the completed line count reaches the programmed size.
  // A size beyond the panel is never reached before the next frame.
  assign hit_split = line_end && line_valid && !sat_ff && !cfg_ff.rotated // [R11]
                     && (10'(line_cnt_ff + 10'h001) == cfg_ff.vsize);    // [R12]

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      second_ff <= 1'b0;
    end else if (vnd_end) begin
      second_ff <= 1'b0;      // [R4]
    end else if (hit_split && !second_ff) begin
      second_ff <= 1'b1;      // [R5] [R7]
    end
  end

  // ---------------------------------------------------------------
  // Address generation
  // ---------------------------------------------------------------
  logic [15:0] addr_q;
  logic        ld;
  logic [15:0] ld_base;
  logic        frame_go_ff;

  // Load one cycle after frame start so the fresh snapshot is used
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_go_ff <= 1'b0;
    end else begin
      frame_go_ff <= vnd_end;
    end
  end

  assign ld      = frame_go_ff || (hit_split && !second_ff);
  assign ld_base = frame_go_ff ? s1_byte : s2_byte; // [R4] [R5]

  ssd_line_addr u_addr (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .load    (ld),
    .base    (ld_base),
    .step    (line_end && line_valid),
    .pitch   (pitch),
    .addr_ff (addr_q)
  );

  // Fetch request is registered data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_req <= '0;
    end else begin
      line_req.byte_addr <= addr_q;
      line_req.second    <= second_ff;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [7:0] nxt_rdata;

  // Unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr)
      `SSD_OFS_S1_LO:    nxt_rdata = s1_lo;
      `SSD_OFS_S1_HI:    nxt_rdata = s1_hi;
      `SSD_OFS_S2_LO:    nxt_rdata = s2_lo;
      `SSD_OFS_S2_HI:    nxt_rdata = s2_hi;
      `SSD_OFS_OFFSET:   nxt_rdata = ofs_q;
      `SSD_OFS_VSIZE_LO: nxt_rdata = vs_lo;
      `SSD_OFS_VSIZE_HI: nxt_rdata = vs_hi;
      `SSD_OFS_CTRL:     nxt_rdata = ctrl_q;
      `SSD_OFS_WIDTH:    nxt_rdata = width_q;
      `SSD_OFS_STATUS:   nxt_rdata = {6'h00, cfg_ff.rotated, second_ff};
      `SSD_OFS_LINE_LO:  nxt_rdata = line_cnt_ff[7:0];
      `SSD_OFS_LINE_HI:  nxt_rdata = {6'h00, line_cnt_ff[9:8]};
      default:           nxt_rdata = 8'h00;
    endcase
  end

  // Data valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_frame_first_img: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
    vnd_end |=> ##1 (addr_q == s1_byte) && !second_ff)
    else $error("frame did not start on first image");

  a_split_to_second: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
    (hit_split && !second_ff) |=> second_ff && (addr_q == s2_byte))
    else $error("split did not switch to second image");

  a_rotated_no_split: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R11]
    (cfg_ff.rotated && !second_ff && !vnd_end) |=> !second_ff)
    else $error("split occurred in rotated mode");

  a_size_no_split: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
    (!second_ff && line_end && line_valid && !vnd_end
     && 10'(line_cnt_ff + 10'h001) != cfg_ff.vsize) |=> !second_ff)
    else $error("second image appeared early");

  a_line_restart: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
    vnd_end |=> line_cnt_ff == 10'h000)
    else $error("line count not cleared at frame start");

  a_snapshot_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R15]
    !vnd_end |=> $stable(cfg_ff))
    else $error("frame settings changed mid-frame");

  a_line_step: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R16]
    (line_end && line_valid && !ld) |=> addr_q == 16'($past(addr_q) + $past(pitch)))
    else $error("line address step wrong");

  a_start_combine: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
    vnd_end |=> cfg_ff.s1_start == 15'($past(s1_hi) * 256 + $past(s1_lo)))
    else $error("start address combine wrong");

  // Checked on the read path, so a wrong mask or a wrong read mux both show up
  a_vsize_width: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
    (reg_rd && reg_addr == `SSD_OFS_VSIZE_HI) |=> reg_rdata[7:2] == 6'h00)
    else $error("unused size bits set");

endmodule
`default_nettype wire

// >>> design/ssd_consts.svh
// Register offsets, field positions and reset values for the split screen start block
`ifndef SSD_CONSTS_SVH
`define SSD_CONSTS_SVH
`define SSD_OFS_S1_LO     6'h0C
`define SSD_OFS_S1_HI     6'h0D
`define SSD_OFS_S2_LO     6'h0F
`define SSD_OFS_S2_HI     6'h10
`define SSD_OFS_OFFSET    6'h12
`define SSD_OFS_VSIZE_LO  6'h13
`define SSD_OFS_VSIZE_HI  6'h14
`define SSD_OFS_CTRL      6'h20
`define SSD_OFS_WIDTH     6'h21
`define SSD_OFS_STATUS    6'h22
`define SSD_OFS_LINE_LO   6'h23
`define SSD_OFS_LINE_HI   6'h24
`define SSD_HI_ADDR_MSK   8'h7F
`define SSD_HI_VSIZE_MSK  8'h03
`define SSD_RST_BYTE      8'h00
`define SSD_RST_VSIZE     10'h3FF
`define SSD_BYTE_SHIFT    8
`endif

// >>> design/ssd_pkg.sv
// Types shared by the split screen start block
package ssd_pkg;
  typedef enum logic [1:0] {SSD_BPP1, SSD_BPP2, SSD_BPP4, SSD_BPP8} ssd_bpp_t;
  // One programmed frame setting, captured together at frame start
  typedef struct packed {
    logic [14:0] s1_start;
    logic [14:0] s2_start;
    logic [9:0]  vsize;
    logic [7:0]  offset;
    logic [7:0]  width;
    logic        rotated;
  } ssd_frame_cfg_t;
  // Per-line fetch request toward the refresh engine
  typedef struct packed {
    logic [15:0] byte_addr;
    logic        second;
  } ssd_line_req_t;
endpackage

// >>> design/ssd_reg_byte.sv
// One byte-wide software register with a writable-bit mask
`timescale 1ns/100ps
`default_nettype none
module ssd_reg_byte
  import ssd_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF
) (
  input  wire logic       sys_clk,  // System clock
  input  wire logic       rst_n,    // Async reset, active low
  input  wire logic       wr_en,    // Write this register
  input  wire logic [7:0] wr_data,  // Write data
  output logic      [7:0] q         // Stored value
);
  // Unused bits are held at zero so they read back as zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 8'h00;
    end else if (wr_en) begin
      q <= wr_data & MASK;
    end
  end
endmodule
`default_nettype wire

// >>> design/ssd_line_addr.sv
// Byte address stepper for the scan lines of one image
`timescale 1ns/100ps
`default_nettype none
module ssd_line_addr
  import ssd_pkg::*;
(
  input  wire logic        sys_clk,   // System clock
  input  wire logic        rst_n,     // Async reset, active low
  input  wire logic        load,      // Load base address
  input  wire logic [15:0] base,      // Base byte address
  input  wire logic        step,      // Advance one scan line
  input  wire logic [15:0] pitch,     // Bytes per virtual line
  output logic      [15:0] addr_ff    // Current line address
);
  logic [15:0] nxt_addr;

  // Load wins over step, a new image restarts from its base
  always_comb begin
    nxt_addr = addr_ff;
    if (load) begin
      nxt_addr = base;
    end else if (step) begin
      nxt_addr = 16'(addr_ff + pitch); // [R16]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= 16'h0000;
    end else begin
      addr_ff <= nxt_addr;
    end
  end
endmodule
`default_nettype wire

// >>> bench/ssd_panel_model.sv
// Refresh timing source and panel model that records each fetched line request
`timescale 1ns/100ps
`default_nettype none
module ssd_panel_model
  import ssd_pkg::*;
(
  input  wire logic          sys_clk,     // System clock
  input  wire ssd_line_req_t line_req,    // Fetch request seen by the panel
  output logic               vnd_end,     // Frame start pulse
  output logic               line_end,    // Line end pulse
  output logic               line_valid   // Line in display area
);
  logic [15:0] seen_addr [0:15];
  logic        seen_sec  [0:15];

  // Idle levels from time zero so the block never sees unknown timing
  initial begin
    vnd_end = 1'b0;
    line_end = 1'b0;
    line_valid = 1'b0;
  end

  // One frame: non-display end, a blank line end, then n displayed lines
  task automatic frame(input int n);
    @(posedge sys_clk) vnd_end <= 1'b1;
    @(posedge sys_clk) vnd_end <= 1'b0;
    repeat (3) @(posedge sys_clk);
    // A line end outside the display area must not be counted
    line_end <= 1'b1;
    @(posedge sys_clk) line_end <= 1'b0;
    for (int k = 0; k < n; k++) begin
      repeat (4) @(posedge sys_clk) line_valid <= 1'b1;
      #1;
      // Sampled well after the last event, where the request has settled
      seen_addr[k] = line_req.byte_addr;
      seen_sec[k] = line_req.second;
      @(posedge sys_clk) line_end <= 1'b1;
      @(posedge sys_clk) line_end <= 1'b0;
      line_valid <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking testbench for the split screen start block
`include "ssd_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench
  import ssd_pkg::*;
();
  logic          sys_clk;
  logic          rst_n;
  logic [5:0]    reg_addr;
  logic [7:0]    reg_wdata;
  logic [7:0]    reg_rdata;
  logic          reg_wr;
  logic          reg_rd;
  logic          vnd_end;
  logic          line_end;
  logic          line_valid;
  ssd_line_req_t line_req;
  ssd_bpp_t      bpp;
  logic [4:0]    pix_per_step;
  logic [7:0]    rb;
  logic [15:0]   pitch;
  int            mismatches;
  int            n_compared;

  ssd_split_start i_ssd_split_start (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vnd_end(vnd_end), .line_end(line_end), .line_valid(line_valid), .line_req(line_req),
    .bpp(bpp), .pix_per_step(pix_per_step));
  ssd_panel_model i_ssd_panel_model (.sys_clk(sys_clk), .line_req(line_req),
    .vnd_end(vnd_end), .line_end(line_end), .line_valid(line_valid));

  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 rb = reg_rdata;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t line address got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic set16(input logic [5:0] lo, input logic [15:0] v);
    wr(lo, v[7:0]);
    wr(lo + 6'h01, v[15:8]);
  endtask

  // Reset level changes on the rising edge like every other input
  task automatic set_reset(input logic lvl);
    @(posedge sys_clk) rst_n <= lvl;
  endtask

  // Lines below vs come from image one, the rest from image two
  task automatic check_frame(input int n, input logic [15:0] b1, input logic [15:0] b2,
                             input int vs);
    logic [15:0] e;
    logic        s;
    for (int k = 0; k < n; k++) begin
      s = (k >= vs);
      e = s ? b2 + 16'((k - vs) * pitch) : b1 + 16'(k * pitch);
      chk_addr(i_ssd_panel_model.seen_addr[k], e);
      chk_bit(i_ssd_panel_model.seen_sec[k], s);
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [5:0] ofs [5];
    ofs = '{`SSD_OFS_S2_LO, `SSD_OFS_S2_HI, `SSD_OFS_VSIZE_LO, `SSD_OFS_VSIZE_HI, 6'h3F};
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk_byte(rb, 8'h00);
    end
    chk_byte({6'h00, bpp}, 8'h00);
    chk_byte({3'h0, pix_per_step}, 8'h10);
  endtask

  task automatic t_regs;
    wr(`SSD_OFS_S2_HI, 8'hFF);
    rd(`SSD_OFS_S2_HI);
    chk_byte(rb, 8'h7F);
    wr(`SSD_OFS_VSIZE_HI, 8'hFF);
    rd(`SSD_OFS_VSIZE_HI);
    chk_byte(rb, 8'h03);
    wr(`SSD_OFS_VSIZE_LO, 8'hC8);
    rd(`SSD_OFS_VSIZE_LO);
    chk_byte(rb, 8'hC8);
    @(posedge sys_clk) #1 chk_byte(reg_rdata, 8'h00);
  endtask

  // Image two below image one in memory, then a one-line scroll down
  task automatic t_split;
    wr(`SSD_OFS_WIDTH, 8'h10);
    wr(`SSD_OFS_OFFSET, 8'h28);
    wr(`SSD_OFS_CTRL, 8'h02);
    pitch = 16'd72;
    set16(`SSD_OFS_S1_LO, 16'h0C80);
    set16(`SSD_OFS_S2_LO, 16'h0000);
    set16(`SSD_OFS_VSIZE_LO, 16'h0003);
    i_ssd_panel_model.frame(6);
    check_frame(6, 16'h1900, 16'h0000, 3);
    // Status keeps the second-image flag and six counted lines until the next frame
    rd(`SSD_OFS_STATUS);
    chk_byte(rb, 8'h01);
    rd(`SSD_OFS_LINE_LO);
    chk_byte(rb, 8'h06);
    // Software scroll adds one virtual line of words to the start
    set16(`SSD_OFS_S1_LO, 16'h0C80 + 16'(pitch / 2));
    set16(`SSD_OFS_S2_LO, 16'h0CA4);
    set16(`SSD_OFS_VSIZE_LO, 16'h0001);
    i_ssd_panel_model.frame(4);
    check_frame(4, 16'h1948, 16'h1948, 1);
  endtask

  // Sizes at the line count, with upper bits set, and zero never split
  task automatic t_nosplit;
    logic [15:0] vs [3];
    vs = '{16'h0006, 16'h0102, 16'h0000};
    foreach (vs[i]) begin
      set16(`SSD_OFS_VSIZE_LO, vs[i]);
      i_ssd_panel_model.frame(6);
      check_frame(6, 16'h1948, 16'h1948, 16);
    end
  endtask

  // A write during a frame must wait for the next frame start
  task automatic t_sample;
    set16(`SSD_OFS_S1_LO, 16'h0010);
    fork
      i_ssd_panel_model.frame(4);
      begin
        repeat (12) @(posedge sys_clk);
        wr(`SSD_OFS_S1_LO, 8'h20);
      end
    join
    check_frame(4, 16'h0020, 16'h0000, 16);
    i_ssd_panel_model.frame(2);
    check_frame(2, 16'h0040, 16'h0000, 16);
  endtask

  // Rotated mode: byte start, halved steps, split ignored
  task automatic t_rotated;
    for (int b = 0; b < 4; b++) begin
      wr(`SSD_OFS_CTRL, 8'(b));
      #1 chk_byte({3'h0, pix_per_step}, 8'(16 >> b));
      wr(`SSD_OFS_CTRL, 8'(b + 4));
      #1 chk_byte({3'h0, pix_per_step}, 8'(8 >> b));
    end
    set16(`SSD_OFS_S1_LO, 16'h0021);
    set16(`SSD_OFS_VSIZE_LO, 16'h0001);
    i_ssd_panel_model.frame(3);
    check_frame(3, 16'h0021, 16'h0000, 16);
  endtask

  // Reset in mid-run: registers and request return to reset, next frame uses them
  task automatic t_midreset;
    set_reset(1'b0);
    repeat (2) @(posedge sys_clk);
    set_reset(1'b1);
    rd(`SSD_OFS_CTRL);
    chk_byte(rb, 8'h00);
    rd(`SSD_OFS_WIDTH);
    chk_byte(rb, 8'hFF);
    chk_addr(line_req.byte_addr, 16'h0000);
    chk_byte({3'h0, pix_per_step}, 8'h10);
    pitch = 16'd510;
    i_ssd_panel_model.frame(2);
    check_frame(2, 16'h0000, 16'h0000, 16);
  endtask

  task automatic finish_test;
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence: reset for three cycles, then every scenario
  initial begin
    rst_n = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pitch = 16'h0000;
    mismatches = 0;
    n_compared = 0;
    repeat (2) @(posedge sys_clk);
    set_reset(1'b1);
    t_reset;
    t_regs;
    t_split;
    t_nosplit;
    t_sample;
    t_rotated;
    t_midreset;
    finish_test;
  end

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    #400000;
    mismatches++;
    finish_test;
  end
endmodule
`default_nettype wire
